/* File: core/msc_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.svh"
module msc_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    input wire logic [23:0] measured_vrms,
    input wire logic meas_done,
    output logic [23:0] vrms_used,
    output msc_pkg::msc_pwr_t power_state,
    output logic init_done,
    output logic conv_busy,
    output logic conv_continuous,
    output logic cal_busy,
    output msc_pkg::msc_cal_t cal_sel
);
    // ****************************************
    // Link side, on the serial clock
    // ****************************************
    logic link_rst;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx_sh, next_rx_sh;
    logic [5:0] ones_run, next_ones_run;
    logic [23:0] tx_sh, next_tx_sh;
    logic [7:0] rx_byte, next_rx_byte;
    logic rx_tog, next_rx_tog;
    logic rd_s1, rd_s2, rd_seen, next_rd_seen;
    logic realign, byte_end;
    logic rd_tog;
    logic [23:0] rd_word;

    assign link_rst = sys_rst | cs_n;

    always_comb begin
        next_rx_sh = {rx_sh[6:0], sdi};
        if (!sdi) begin
            next_ones_run = '0;
        end else if (ones_run == `MSC_RUN_MAX) begin
            next_ones_run = ones_run;
        end else begin
            next_ones_run = ones_run + 6'h01;
        end
        realign = !sdi && (ones_run >= `MSC_SYNC_RUN);
        byte_end = realign || (bit_cnt == `MSC_BYTE_LAST);
        next_bit_cnt = realign ? 3'h0 : bit_cnt + 3'h1;
        next_rx_byte = rx_byte;
        next_rx_tog = rx_tog;
        next_rd_seen = rd_seen;
        next_tx_sh = {tx_sh[22:0], 1'b0};
        if (byte_end) begin
            next_rx_byte = next_rx_sh;
            next_rx_tog = ~rx_tog;
            if (rd_s2 != rd_seen) begin
                next_tx_sh = rd_word;
                next_rd_seen = rd_s2;
            end
        end
    end

    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= '0;
            rx_sh <= '0;
            ones_run <= '0;
            tx_sh <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
            ones_run <= next_ones_run;
            tx_sh <= next_tx_sh;
        end
    end

    // Handshake state survives chip-select so no phantom byte appears
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_byte <= '0;
            rx_tog <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rd_seen <= 1'b0;
        end else begin
            rx_byte <= next_rx_byte;
            rx_tog <= next_rx_tog;
            rd_s1 <= rd_tog;
            rd_s2 <= rd_s1;
            rd_seen <= next_rd_seen;
        end
    end

    assign sdo = tx_sh[23];

    // ****************************************
    // Command decoder and sequencer
    // ****************************************
    function automatic msc_pkg::msc_cmd_t classify(input logic [7:0] b);
        if (!b[7] && !b[0]) begin
            classify = b[6] ? msc_pkg::MSC_CMD_WRITE : msc_pkg::MSC_CMD_READ;
        end else if (b[7:1] == `MSC_SYNC_HI) begin
            classify = msc_pkg::MSC_CMD_SYNC;
        end else if (b[7:4] == `MSC_OP_CONV && b[2:0] == 3'h0) begin
            classify = msc_pkg::MSC_CMD_CONV;
        end else if (b[7:6] == `MSC_OP_INSTR && b[3:0] == 4'h0) begin
            classify = msc_pkg::MSC_CMD_PWR;
        end else if (b[7:6] == `MSC_OP_INSTR) begin
            classify = msc_pkg::MSC_CMD_CAL;
        end else begin
            classify = msc_pkg::MSC_CMD_BAD;
        end
    endfunction

    function automatic logic [23:0] default_of(input logic [6:0] a);
        default_of = (a == `MSC_VFRMS_ADDR) ? `MSC_VFRMS_RST : 24'h000000;
    endfunction

    logic tog_s1, tog_s2, tog_s3, new_byte;
    logic [7:0] cmd_byte;
    msc_pkg::msc_cmd_t cmd;
    msc_pkg::msc_seq_t seq, next_seq;
    msc_pkg::msc_pwr_t next_power_state;
    logic [6:0] init_addr, next_init_addr;
    logic next_init_done, do_init;
    logic [1:0] wr_left, next_wr_left;
    logic [6:0] wr_addr, next_wr_addr;
    logic [15:0] wr_data, next_wr_data;
    logic [23:0] page, next_page, mode, next_mode, vfrms, next_vfrms;
    logic next_conv_cont, next_rd_tog, rd_pend, next_rd_pend;
    logic [4:0] rd_ra, next_rd_ra;
    logic [23:0] next_rd_word, mem_rd_data, next_vrms_used;
    logic [6:0] mem_rd_addr;
    msc_pkg::msc_mem_wr_t mem_wr;
    msc_pkg::msc_cal_t next_cal_sel;

    assign new_byte = tog_s2 ^ tog_s3;
    assign cmd_byte = rx_byte;
    assign cmd = classify(cmd_byte);

    always_comb begin
        next_seq = seq;
        next_power_state = power_state;
        next_init_addr = init_addr;
        next_init_done = init_done;
        next_wr_left = wr_left;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_page = page;
        next_mode = mode;
        next_vfrms = vfrms;
        next_conv_cont = conv_continuous;
        next_cal_sel = cal_sel;
        next_rd_tog = rd_tog;
        next_rd_word = rd_word;
        next_rd_pend = 1'b0;
        next_rd_ra = rd_ra;
        do_init = 1'b0;
        mem_wr = '0;
        mem_rd_addr = {page[1:0], cmd_byte[5:1]};
        if (seq == msc_pkg::MSC_INIT) begin
            mem_wr = '{1'b1, init_addr, default_of(init_addr)};
            next_init_addr = init_addr + 7'h01;
            if (init_addr == `MSC_LAST_ADDR) begin
                next_seq = msc_pkg::MSC_IDLE;
                next_init_done = 1'b1;
            end
        end
        if (rd_pend) begin
            next_rd_tog = ~rd_tog;
            if (rd_ra == `MSC_PAGE_RA) begin
                next_rd_word = page;
            end else if (rd_ra == `MSC_STATUS_RA) begin
                next_rd_word = '0;
                next_rd_word[`MSC_DONE_BIT] = init_done;
            end else begin
                next_rd_word = mem_rd_data;
            end
        end
        if (meas_done && (seq == msc_pkg::MSC_CAL ||
            (seq == msc_pkg::MSC_CONV && !conv_continuous))) begin
            next_seq = msc_pkg::MSC_IDLE;
        end
        if (new_byte) begin
            if (wr_left != 2'h0) begin
                next_wr_data = {wr_data[7:0], cmd_byte};
                next_wr_left = wr_left - 2'h1;
                if (wr_left == 2'h1) begin
                    mem_wr = '{1'b1, wr_addr, {wr_data, cmd_byte}};
                    if (wr_addr[4:0] == `MSC_PAGE_RA) begin
                        next_page = {wr_data, cmd_byte};
                    end
                    if (wr_addr == `MSC_MODE_ADDR) begin
                        next_mode = {wr_data, cmd_byte};
                    end
                    if (wr_addr == `MSC_VFRMS_ADDR) begin
                        next_vfrms = {wr_data, cmd_byte};
                    end
                end
            end else if (power_state == msc_pkg::MSC_SLEEP) begin
                if (cmd == msc_pkg::MSC_CMD_PWR &&
                    cmd_byte[5:4] == `MSC_PWR_WAKE) begin
                    do_init = 1'b1;
                end
            end else begin
                case (cmd)
                    msc_pkg::MSC_CMD_READ: begin
                        next_rd_pend = 1'b1;
                        next_rd_ra = cmd_byte[5:1];
                    end
                    msc_pkg::MSC_CMD_WRITE: begin
                        next_wr_left = `MSC_WR_BYTES;
                        next_wr_addr = {page[1:0], cmd_byte[5:1]};
                    end
                    msc_pkg::MSC_CMD_CONV: begin
                        next_seq = msc_pkg::MSC_CONV;
                        next_conv_cont = cmd_byte[`MSC_CC_BIT];
                    end
                    msc_pkg::MSC_CMD_CAL: begin
                        next_seq = msc_pkg::MSC_CAL;
                        next_cal_sel = '{cmd_byte[5:4], cmd_byte[3:0]};
                    end
                    msc_pkg::MSC_CMD_PWR: begin
                        next_seq = msc_pkg::MSC_IDLE;
                        case (cmd_byte[5:4])
                            `MSC_PWR_RESET: do_init = 1'b1;
                            `MSC_PWR_SLEEP: next_power_state = msc_pkg::MSC_SLEEP;
                            `MSC_PWR_STBY: next_power_state = msc_pkg::MSC_STANDBY;
                            default: next_power_state = msc_pkg::MSC_ACTIVE;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
        if (do_init) begin
            next_seq = msc_pkg::MSC_INIT;
            next_init_addr = '0;
            next_init_done = 1'b0;
            next_power_state = msc_pkg::MSC_ACTIVE;
            next_page = '0;
            next_mode = '0;
            next_vfrms = `MSC_VFRMS_RST;
            next_conv_cont = 1'b0;
            next_wr_left = '0;
        end
        next_vrms_used = mode[`MSC_FIXED_VRMS_SELECT_BIT] ? vfrms : measured_vrms;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            seq <= msc_pkg::MSC_INIT;
            power_state <= msc_pkg::MSC_ACTIVE;
            init_addr <= '0;
            init_done <= 1'b0;
            wr_left <= '0;
            wr_addr <= '0;
            wr_data <= '0;
            page <= '0;
            mode <= '0;
            vfrms <= `MSC_VFRMS_RST;
            conv_continuous <= 1'b0;
            conv_busy <= 1'b0;
            cal_busy <= 1'b0;
            cal_sel <= '0;
            rd_tog <= 1'b0;
            rd_word <= '0;
            rd_pend <= 1'b0;
            rd_ra <= '0;
            vrms_used <= '0;
        end else begin
            tog_s1 <= rx_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            seq <= next_seq;
            power_state <= next_power_state;
            init_addr <= next_init_addr;
            init_done <= next_init_done;
            wr_left <= next_wr_left;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            page <= next_page;
            mode <= next_mode;
            vfrms <= next_vfrms;
            conv_continuous <= next_conv_cont;
            conv_busy <= (next_seq == msc_pkg::MSC_CONV);
            cal_busy <= (next_seq == msc_pkg::MSC_CAL);
            cal_sel <= next_cal_sel;
            rd_tog <= next_rd_tog;
            rd_word <= next_rd_word;
            rd_pend <= next_rd_pend;
            rd_ra <= next_rd_ra;
            vrms_used <= next_vrms_used;
        end
    end

    msc_regmem u_regmem (
        .clk(sys_clk),
        .wr(mem_wr),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // ****************************************
    // Assertions
    // ****************************************
    logic awake;
    assign awake = new_byte && wr_left == 2'h0 &&
        power_state != msc_pkg::MSC_SLEEP;

    property p_init_after_reset;
        @(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> seq == msc_pkg::MSC_INIT && !init_done;
    endproperty
    a_init_after_reset: assert property (p_init_after_reset)
        else $error("init walk not started after reset");
    property p_done_after_walk;
        @(posedge sys_clk) disable iff (sys_rst)
        (seq == msc_pkg::MSC_INIT && init_addr == `MSC_LAST_ADDR &&
        !new_byte) |=> init_done && seq == msc_pkg::MSC_IDLE;
    endproperty
    a_done_after_walk: assert property (p_done_after_walk)
        else $error("init done flag missing after walk");
    property p_soft_reset;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd_byte == 8'h80) |=> seq == msc_pkg::MSC_INIT
        ##128 init_done;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset did not rerun init");
    property p_standby_keeps;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd_byte == 8'ha0 &&
        power_state == msc_pkg::MSC_STANDBY) |=>
        power_state == msc_pkg::MSC_ACTIVE && $stable(page);
    endproperty
    a_standby_keeps: assert property (p_standby_keeps)
        else $error("wake from stand-by lost state");
    property p_sleep_wake;
        @(posedge sys_clk) disable iff (sys_rst)
        (new_byte && wr_left == 2'h0 && cmd_byte == 8'ha0 &&
        power_state == msc_pkg::MSC_SLEEP) |=> seq == msc_pkg::MSC_INIT;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("wake from sleep did not reinitialize");
    property p_fixed_vrms;
        @(posedge sys_clk) disable iff (sys_rst)
        mode[`MSC_FIXED_VRMS_SELECT_BIT] |=> vrms_used == $past(vfrms);
    endproperty
    a_fixed_vrms: assert property (p_fixed_vrms)
        else $error("fixed rms value not substituted");
    property p_conv_start;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd_byte == 8'he8) |=> conv_busy && conv_continuous;
    endproperty
    a_conv_start: assert property (p_conv_start)
        else $error("continuous conversion not started");
    property p_cal_start;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd == msc_pkg::MSC_CMD_CAL) |=> cal_busy &&
        cal_sel == $past(cmd_byte[5:0]);
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration select not taken");
    property p_read_answer;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd == msc_pkg::MSC_CMD_READ) |=> ##1 rd_tog != $past(rd_tog);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read word not handed to link");
    property p_bad_ignored;
        @(posedge sys_clk) disable iff (sys_rst)
        (awake && cmd == msc_pkg::MSC_CMD_BAD && seq == msc_pkg::MSC_IDLE &&
        !rd_pend) |=> $stable(seq) && $stable(power_state) && wr_left == 2'h0;
    endproperty
    a_bad_ignored: assert property (p_bad_ignored)
        else $error("undefined byte changed state");
    property p_realign;
        @(posedge sclk) disable iff (link_rst)
        (!sdi && ones_run >= `MSC_SYNC_RUN) |=> bit_cnt == 3'h0 &&
        rx_byte == 8'hfe;
    endproperty
    a_realign: assert property (p_realign)
        else $error("sync sequence did not realign");

    c_soft_reset: cover property (@(posedge sys_clk)
        awake && cmd_byte == 8'h80);
    c_conv: cover property (@(posedge sys_clk) conv_busy && conv_continuous);
    c_write: cover property (@(posedge sys_clk) mem_wr.en && wr_left == 2'h1);
    c_realign: cover property (@(posedge sclk) realign);
endmodule
`default_nettype wire

/* File: core/msc_consts.svh */
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_ADDR_W 7
`define MSC_DATA_W 24
`define MSC_LAST_ADDR 7'h7f
`define MSC_PAGE_RA 5'h1f
`define MSC_STATUS_RA 5'h0f
`define MSC_MODE_ADDR 7'h21
`define MSC_VFRMS_ADDR 7'h22
`define MSC_FIXED_VRMS_SELECT_BIT 0
`define MSC_DONE_BIT 23
`define MSC_VFRMS_RST 24'hb504f7
`define MSC_SYNC_RUN 6'h1f
`define MSC_RUN_MAX 6'h3f
`define MSC_BYTE_LAST 3'h7
`define MSC_WR_BYTES 2'h3
`define MSC_SYNC_HI 7'h7f
`define MSC_OP_CONV 4'he
`define MSC_OP_INSTR 2'h2
`define MSC_CC_BIT 3
`define MSC_PWR_RESET 2'h0
`define MSC_PWR_SLEEP 2'h1
`define MSC_PWR_WAKE 2'h2
`define MSC_PWR_STBY 2'h3
`endif

/* File: core/msc_pkg.sv */
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_ACTIVE = 2'b00,
        MSC_STANDBY = 2'b01,
        MSC_SLEEP = 2'b10
    } msc_pwr_t;
    typedef enum logic [1:0] {
        MSC_IDLE = 2'b00,
        MSC_INIT = 2'b01,
        MSC_CONV = 2'b10,
        MSC_CAL = 2'b11
    } msc_seq_t;
    typedef enum logic [2:0] {
        MSC_CMD_READ = 3'b000,
        MSC_CMD_WRITE = 3'b001,
        MSC_CMD_SYNC = 3'b010,
        MSC_CMD_CONV = 3'b011,
        MSC_CMD_PWR = 3'b100,
        MSC_CMD_CAL = 3'b101,
        MSC_CMD_BAD = 3'b110
    } msc_cmd_t;
    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] chan;
    } msc_cal_t;
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [23:0] data;
    } msc_mem_wr_t;
endpackage

/* File: core/msc_regmem.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_regmem (
    input wire logic clk,
    input wire msc_pkg::msc_mem_wr_t wr,
    input wire logic [6:0] rd_addr,
    output logic [23:0] rd_data
);
    logic [23:0] mem [0:127];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* File: bench/msc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host side of the serial command port
// ****************************************
module msc_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic sdi,
    input wire logic sdo
);
    localparam int HALF = 15;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // Bits MSB first; sdo taken while sclk is low
    task automatic send_bits(input int n, input logic [7:0] tx,
                             output logic [7:0] rx);
        rx = 8'h00;
        if (cs_n) begin
            cs_n = 1'b0;
            #(2 * HALF);
        end
        for (int i = n - 1; i >= 0; i--) begin
            sdi = tx[i];
            #HALF;
            rx = {rx[6:0], sdo};
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
    endtask
    // Clock stands still; data line shows the inverse
    task automatic end_frame();
        #HALF;
        cs_n = 1'b1;
        sdi = ~sdi;
        #(2 * HALF);
    endtask
    task automatic read_reg(input logic [4:0] ra, input logic [7:0] tx0,
                            output logic [23:0] data);
        logic [7:0] b0, b1, b2, junk;
        send_bits(8, {2'b00, ra, 1'b0}, junk);
        send_bits(8, 8'hfe, junk);
        send_bits(8, tx0, b0);
        send_bits(8, 8'hfe, b1);
        send_bits(8, 8'hfe, b2);
        data = {b0, b1, b2};
    endtask
    task automatic write_reg(input logic [4:0] ra, input logic [23:0] d);
        logic [7:0] junk;
        send_bits(8, {2'b01, ra, 1'b0}, junk);
        send_bits(8, d[23:16], junk);
        send_bits(8, d[15:8], junk);
        send_bits(8, d[7:0], junk);
    endtask
endmodule
`default_nettype wire

/* File: bench/meter_serial_command_decoder_test.sv */
`timescale 1ns/1ns
`default_nettype none
module meter_serial_command_decoder_test;
    logic sys_clk, sys_rst, sclk, cs_n, sdi, sdo, meas_done;
    logic init_done, conv_busy, conv_continuous, cal_busy;
    logic [23:0] measured_vrms, vrms_used, rd;
    logic [7:0] junk;
    msc_pkg::msc_pwr_t power_state;
    msc_pkg::msc_cal_t cal_sel;
    int bad_count = 0;
    int samples_checked = 0;
    logic [3:0] masks [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    msc_core dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo(sdo), .measured_vrms(measured_vrms),
        .meas_done(meas_done), .vrms_used(vrms_used),
        .power_state(power_state), .init_done(init_done),
        .conv_busy(conv_busy), .conv_continuous(conv_continuous),
        .cal_busy(cal_busy), .cal_sel(cal_sel)
    );
    msc_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host.send_bits(8, b, junk);
        settle();
    endtask
    task automatic wait_init();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        meas_done = 1'b0;
        measured_vrms = 24'h3c3c3c;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        settle();
        check(24'(init_done), 24'h000000);
        wait_init();
        check(24'(init_done), 24'h000001);
        u_host.read_reg(5'h0f, 8'hfe, rd);
        check(rd, 24'h800000);
        u_host.read_reg(5'h1f, 8'hfe, rd);
        check(rd, 24'h000000);
        u_host.write_reg(5'h1f, 24'h000001);
        u_host.read_reg(5'h1f, 8'hfe, rd);
        check(rd, 24'h000001);
        u_host.read_reg(5'h02, 8'hfe, rd);
        check(rd, 24'hb504f7);
        check(vrms_used, 24'h3c3c3c);
        u_host.write_reg(5'h01, 24'h000001);
        settle();
        check(vrms_used, 24'hb504f7);
        u_host.write_reg(5'h02, 24'h123456);
        settle();
        check(vrms_used, 24'h123456);
        u_host.send_bits(8, 8'h04, junk);
        u_host.read_reg(5'h1f, 8'he0, rd);
        check(rd, 24'h000001);
        check(24'(conv_busy), 24'h000001);
        check(24'(conv_continuous), 24'h000000);
        @(negedge sys_clk) meas_done = 1'b1;
        @(negedge sys_clk) meas_done = 1'b0;
        settle();
        check(24'(conv_busy), 24'h000000);
        cmd(8'he8);
        check(24'(conv_continuous), 24'h000001);
        cmd(8'hc0);
        cmd(8'he1);
        check(24'(conv_busy), 24'h000001);
        cmd(8'ha0);
        check(24'(conv_busy), 24'h000000);
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 5; j++) begin
                cmd({2'b10, k[1:0], masks[j]});
                check(24'(cal_busy), 24'h000001);
                check(24'(cal_sel), 24'({k[1:0], masks[j]}));
            end
        end
        cmd(8'he0);
        check(24'({cal_busy, conv_busy}), 24'h000001);
        cmd(8'hb0);
        check(24'(power_state), 24'(msc_pkg::MSC_STANDBY));
        cmd(8'ha0);
        check(24'(power_state), 24'(msc_pkg::MSC_ACTIVE));
        u_host.read_reg(5'h1f, 8'hfe, rd);
        check(rd, 24'h000001);
        cmd(8'h90);
        check(24'(power_state), 24'(msc_pkg::MSC_SLEEP));
        cmd(8'ha0);
        check(24'(init_done), 24'h000000);
        wait_init();
        check(24'(power_state), 24'(msc_pkg::MSC_ACTIVE));
        u_host.read_reg(5'h1f, 8'hfe, rd);
        check(rd, 24'h000000);
        // Page 1 so that the mode bit is really set before soft reset
        u_host.write_reg(5'h1f, 24'h000001);
        u_host.write_reg(5'h01, 24'h000001);
        settle();
        check(vrms_used, 24'hb504f7);
        cmd(8'h80);
        check(24'(init_done), 24'h000000);
        wait_init();
        check(vrms_used, 24'h3c3c3c);
        u_host.read_reg(5'h1f, 8'hfe, rd);
        check(rd, 24'h000000);
        u_host.send_bits(3, 8'h05, junk);
        u_host.end_frame();
        u_host.read_reg(5'h0f, 8'hfe, rd);
        check(rd, 24'h800000);
        u_host.send_bits(3, 8'h06, junk);
        repeat (3) u_host.send_bits(8, 8'hff, junk);
        u_host.send_bits(8, 8'hfe, junk);
        u_host.read_reg(5'h0f, 8'hfe, rd);
        check(rd, 24'h800000);
        u_host.end_frame();
        tally_and_finish();
    end
    initial begin
        #300000;
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
